//--- common/secs_pkg.sv
// Notes on behaviour
// R01 - accumulator average rate follows 65536 minus divisor, over 65536
// R02 - frame cycles grow only in whole steps
// R03 - 48MHz, 8+2 bits: 0-406 give 160
// R04 - compare seven or eight bits by mode
// R05 - masked bits ignored; zero exact, ones all
// R06 - two-address mode matches either value
// R07 - range mode: lower mask, upper match, inclusive
// R08 - each source sets its own flag
// R09 - enable set/clear by writing ones only
// R10 - request when flag set and enabled
// R11 - request holds until clear, disable, reset
// R12 - one shared request line, flags name cause
// R13 - registers classed by synchronization need
// R14 - busy sets at once, clears when done
// R15 - sync completion raises ready flag
// R16 - sync access while busy stalls, never drops
// R17 - keeps running whenever its clock runs
// R18 - one buffered word behind transmit shifter
// R19 - two-entry receive buffer
// R20 - address match only in spi, two-wire modes
// R21 - arithmetic divisor is sixteen bits
// R22 - writing one clears flag, zero keeps
// R23 - software polls busy before synced accesses
package secs_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN_CLR = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN_SET = 8'h10;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CPF = 8'h1c;
    localparam logic [7:0] OFS_DATA = 8'h20;
    // ------------------------------------------------------------
    // fields and encodings
    // ------------------------------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_AMODE_LO = 4;
    localparam int ADDR_MASK_LO = 16;
    localparam int IRQ_TXE = 0;
    localparam int IRQ_RXC = 1;
    localparam int IRQ_AM = 2;
    localparam int IRQ_SRDY = 3;
    localparam logic [2:0] MODE_SPI_S = 3'h2;
    localparam logic [2:0] MODE_SPI_M = 3'h3;
    localparam logic [2:0] MODE_I2C_S = 3'h4;
    localparam logic [2:0] MODE_I2C_M = 3'h5;
    localparam logic [1:0] AMODE_MASK = 2'h0;
    localparam logic [1:0] AMODE_TWO = 2'h1;
    localparam logic [1:0] AMODE_RANGE = 2'h2;
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_ON_WR = 2'h1;
    localparam logic [1:0] SYNC_ON_RD = 2'h2;
    localparam logic [1:0] SYNC_ON_WR_RD = 2'h3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SYNC_TIME_NS = 60;
    localparam int SYNC_CYCLES =
        (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SYNC_LOAD = 3'(SYNC_CYCLES);
    localparam logic [16:0] ACC_ONE = 17'h10000;
    localparam logic [3:0] SMP_LAST = 4'hf;
    localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
    // ten bits of sixteen ticks plus a small margin, so that divisor
    // 406 still counts 160 cycles and 407 already counts 161
    localparam logic [24:0] FRAME_LIMIT = 25'h0a00040;
    localparam logic [15:0] CPF_AT_ZERO = 16'h00a0;
    typedef enum logic [1:0] {CPF_IDLE = 2'b01, CPF_RUN = 2'b10} secs_cpf_e;
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} secs_tx_e;
endpackage

//--- hw/secs_core.sv
`timescale 1ns/100ps
module secs_core
    import secs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic txd,
    input wire logic [7:0] rx_word,
    input wire logic rx_word_valid,
    output logic rx_word_ready,
    input wire logic [7:0] addr_in,
    input wire logic addr_valid,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] ctrl_bus;
        logic [5:0] ctrl_core;
        logic [15:0] baud_bus;
        logic [15:0] baud_core;
        logic [7:0] match;
        logic [7:0] mask2;
        logic [3:0] irq_en;
        logic [3:0] irq_flag;
        logic [2:0] sync_cnt;
        logic [15:0] acc;
        logic [3:0] smp_cnt;
        secs_cpf_e cpf_st;
        logic [24:0] cpf_sum;
        logic [15:0] cpf_cnt;
        logic [15:0] cpf_val;
        secs_tx_e tx_st;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [9:0] tx_shift;
        logic [3:0] tx_bits;
        logic txd;
        logic [1:0][7:0] rx_mem;
        logic rx_wp;
        logic rx_rp;
        logic [1:0] rx_cnt;
        logic [31:0] prdata;
    } secs_state_s;

    localparam secs_state_s S_RST = '{
        cpf_st: CPF_RUN, tx_st: TX_IDLE, txd: 1'b1, default: '0};

    secs_state_s s_r;
    secs_state_s s_nxt;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    function automatic logic [1:0] sync_class(input logic [7:0] a);
        case (a) // R13
            OFS_CTRL: sync_class = SYNC_ON_WR;
            OFS_BAUD: sync_class = SYNC_ON_WR;
            OFS_CPF: sync_class = SYNC_ON_RD;
            default: sync_class = SYNC_NONE;
        endcase
    endfunction

    function automatic logic needs_sync(input logic [7:0] a,
                                        input logic w);
        logic [1:0] c;
        c = sync_class(a);
        needs_sync = w ? c[0] : c[1];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= OFS_DATA);
    endfunction

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] m,
                                      input logic [7:0] k,
                                      input logic [1:0] amode,
                                      input logic wide);
        logic [7:0] keep;
        logic [7:0] ax;
        logic [7:0] mx;
        logic [7:0] kx;
        keep = wide ? 8'hff : 8'h7f; // R04
        ax = a & keep;
        mx = m & keep;
        kx = k & keep;
        case (amode)
            AMODE_MASK: addr_hit = ((ax ^ mx) & ~kx) == 8'h00; // R05
            AMODE_TWO: addr_hit = (ax == mx) || (ax == kx); // R06
            AMODE_RANGE: addr_hit = (ax <= mx) && (ax >= kx); // R07
            default: addr_hit = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // bus handshake and sync
    // ------------------------------------------------------------
    logic busy;
    logic sync_req;
    logic acc_ok;
    logic wr_acc;
    logic rd_acc;
    logic sync_done;
    logic en;
    logic [2:0] mode;
    logic match_en;
    logic hit;
    logic [16:0] step;
    logic [16:0] sum;
    logic smp_tick;
    logic bit_tick;
    logic frame_end;
    logic tx_load;
    logic rx_push;
    logic rx_pop;
    logic [3:0] flag_set;
    logic [31:0] rd_mux;

    assign busy = s_r.sync_cnt != 3'h0;
    assign sync_req = psel && needs_sync(paddr, pwrite);
    assign pready = pce && !(sync_req && busy); // R16 R23
    assign acc_ok = psel && penable && pready;
    assign wr_acc = acc_ok && pwrite;
    assign rd_acc = acc_ok && !pwrite;
    assign pslverr = acc_ok && !mapped(paddr);
    assign sync_done = s_r.sync_cnt == 3'h1;

    // ------------------------------------------------------------
    // serial engine timing
    // ------------------------------------------------------------
    assign en = s_r.ctrl_core[CTRL_EN];
    assign mode = s_r.ctrl_core[CTRL_MODE_LO +: 3];
    assign match_en = en && (mode == MODE_SPI_S || mode == MODE_SPI_M ||
                             mode == MODE_I2C_S || mode == MODE_I2C_M); // R20
    assign hit = match_en && addr_valid &&
                 addr_hit(addr_in, s_r.match, s_r.mask2,
                          s_r.ctrl_core[CTRL_AMODE_LO +: 2],
                          mode == MODE_SPI_S || mode == MODE_SPI_M);
    assign step = ACC_ONE - {1'b0, s_r.baud_core}; // R21
    assign sum = {1'b0, s_r.acc} + step; // R01
    assign smp_tick = en && sum[16]; // R17
    assign bit_tick = smp_tick && s_r.smp_cnt == SMP_LAST;
    assign frame_end = s_r.tx_st == TX_SHIFT && bit_tick &&
                       s_r.tx_bits == FRAME_LAST_BIT;
    assign tx_load = en && s_r.tx_full &&
                     (s_r.tx_st == TX_IDLE || frame_end); // R18
    assign rx_word_ready = s_r.rx_cnt != 2'h2; // R19
    assign rx_push = rx_word_valid && rx_word_ready;
    assign rx_pop = rd_acc && paddr == OFS_DATA && s_r.rx_cnt != 2'h0;
    assign flag_set = {sync_done, hit, rx_push, tx_load}; // R08 R15

    always_comb begin
        case (paddr)
            OFS_CTRL: rd_mux = {26'h0, s_r.ctrl_bus};
            OFS_BAUD: rd_mux = {16'h0, s_r.baud_bus};
            OFS_ADDR: rd_mux = {8'h0, s_r.mask2, 8'h0, s_r.match};
            OFS_IRQ_EN_CLR: rd_mux = {28'h0, s_r.irq_en};
            OFS_IRQ_EN_SET: rd_mux = {28'h0, s_r.irq_en};
            OFS_IRQ_FLAG: rd_mux = {28'h0, s_r.irq_flag};
            OFS_STATUS: rd_mux = {31'h0, busy};
            OFS_CPF: rd_mux = {16'h0, s_r.cpf_val};
            OFS_DATA: rd_mux = {24'h0, s_r.rx_mem[s_r.rx_rp]};
            default: rd_mux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [24:0] csum;
        logic [3:0] clr;
        csum = s_r.cpf_sum + {8'h0, step};
        clr = 4'h0;
        s_nxt = s_r;
        s_nxt.prdata = psel ? rd_mux : s_r.prdata;
        // register writes
        if (wr_acc) begin
            case (paddr)
                OFS_CTRL: s_nxt.ctrl_bus = pwdata[5:0];
                OFS_BAUD: s_nxt.baud_bus = pwdata[15:0];
                OFS_ADDR: begin
                    s_nxt.match = pwdata[7:0];
                    s_nxt.mask2 = pwdata[ADDR_MASK_LO +: 8];
                end
                OFS_IRQ_EN_CLR:
                    s_nxt.irq_en = s_r.irq_en & ~pwdata[3:0]; // R09
                OFS_IRQ_EN_SET: s_nxt.irq_en = s_r.irq_en | pwdata[3:0]; // R09
                OFS_IRQ_FLAG: clr = pwdata[3:0]; // R22
                default: ;
            endcase
        end
        s_nxt.irq_flag = (s_r.irq_flag & ~clr) | flag_set; // R11
        // cross-domain transfer
        if (acc_ok && needs_sync(paddr, pwrite)) begin
            s_nxt.sync_cnt = SYNC_LOAD; // R14
        end else if (busy) begin
            s_nxt.sync_cnt = s_r.sync_cnt - 3'h1;
        end
        if (sync_done) begin
            s_nxt.ctrl_core = s_r.ctrl_bus;
            s_nxt.baud_core = s_r.baud_bus;
        end
        // rate generator
        s_nxt.acc = en ? sum[15:0] : 16'h0;
        // phase held at zero while idle, so a start bit gets full ticks
        if (s_r.tx_st == TX_IDLE) begin
            s_nxt.smp_cnt = 4'h0;
        end else if (smp_tick) begin
            s_nxt.smp_cnt = s_r.smp_cnt + 4'h1;
        end
        // cycles per frame, floor of whole cycles
        case (s_r.cpf_st)
            CPF_RUN: begin
                if (csum <= FRAME_LIMIT) begin // R02
                    s_nxt.cpf_sum = csum;
                    s_nxt.cpf_cnt = s_r.cpf_cnt + 16'h1;
                end else begin
                    s_nxt.cpf_val = s_r.cpf_cnt; // R03
                    s_nxt.cpf_st = CPF_IDLE;
                end
            end
            CPF_IDLE: ;
            default: s_nxt.cpf_st = CPF_IDLE;
        endcase
        if (sync_done) begin
            s_nxt.cpf_st = CPF_RUN;
            s_nxt.cpf_sum = 25'h0;
            s_nxt.cpf_cnt = 16'h0;
        end
        // transmitter
        case (s_r.tx_st)
            TX_IDLE: s_nxt.txd = 1'b1;
            TX_SHIFT: begin
                if (frame_end) begin
                    s_nxt.tx_st = TX_IDLE;
                    s_nxt.txd = 1'b1;
                end else if (bit_tick) begin
                    s_nxt.tx_shift = {1'b1, s_r.tx_shift[9:1]};
                    s_nxt.txd = s_r.tx_shift[1];
                    s_nxt.tx_bits = s_r.tx_bits + 4'h1;
                end
            end
            default: s_nxt.tx_st = TX_IDLE;
        endcase
        if (tx_load) begin
            s_nxt.tx_st = TX_SHIFT; // R18
            s_nxt.tx_shift = {1'b1, s_r.tx_buf, 1'b0};
            s_nxt.tx_bits = 4'h0;
            s_nxt.txd = 1'b0;
            s_nxt.tx_full = 1'b0;
        end
        if (wr_acc && paddr == OFS_DATA && (!s_r.tx_full || tx_load)) begin
            s_nxt.tx_buf = pwdata[7:0];
            s_nxt.tx_full = 1'b1;
        end
        // receive buffer
        if (rx_push) begin
            s_nxt.rx_mem[s_r.rx_wp] = rx_word; // R19
            s_nxt.rx_wp = ~s_r.rx_wp;
        end
        if (rx_pop) begin
            s_nxt.rx_rp = ~s_r.rx_rp;
        end
        s_nxt.rx_cnt = s_r.rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= S_RST;
        end else if (pce) begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign txd = s_r.txd;
    assign irq = |(s_r.irq_flag & s_r.irq_en); // R10 R12

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int SYNC_N = SYNC_CYCLES;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !pce);

    a_sync_busy_now: assert property ( // R14
        acc_ok && needs_sync(paddr, pwrite) |=> busy)
        else $error("busy not set after synced access");
    a_sync_busy_end: assert property ( // R14
        $rose(busy) && !sync_req |-> ##[SYNC_N:SYNC_N] !busy || sync_req)
        else $error("busy did not clear in time");
    a_sync_stall: assert property ( // R16
        psel && penable && sync_req && busy |-> !pready)
        else $error("synced access not stalled while busy");
    a_sync_ready: assert property ( // R15
        busy && s_r.sync_cnt == 3'h1 |=> s_r.irq_flag[IRQ_SRDY])
        else $error("sync ready flag missing");
    a_irq_holds: assert property ( // R11
        irq && !(wr_acc && (paddr == OFS_IRQ_FLAG ||
                            paddr == OFS_IRQ_EN_CLR)) |=> irq)
        else $error("request dropped without clear or disable");
    a_enable_set: assert property ( // R09
        wr_acc && paddr == OFS_IRQ_EN_SET
        |=> (s_r.irq_en & $past(pwdata[3:0])) == $past(pwdata[3:0]))
        else $error("enable set failed");
    a_flag_clear: assert property ( // R22
        wr_acc && paddr == OFS_IRQ_FLAG && pwdata[IRQ_AM] && !hit
        |=> !s_r.irq_flag[IRQ_AM])
        else $error("flag not cleared");
    a_match_gate: assert property ( // R20
        !match_en && !s_r.irq_flag[IRQ_AM] |=> !s_r.irq_flag[IRQ_AM])
        else $error("match outside spi or two-wire modes");
    a_cpf_zero: assert property ( // R03
        s_r.cpf_st == CPF_RUN && s_r.baud_core == 16'h0 && !sync_done
        ##1 s_r.cpf_st == CPF_IDLE |-> s_r.cpf_val == CPF_AT_ZERO)
        else $error("frame cycles wrong at zero divisor");
    a_tx_no_gap: assert property ( // R18
        frame_end && s_r.tx_full |=> s_r.tx_st == TX_SHIFT && !txd)
        else $error("gap between buffered frames");
    a_tx_start: assert property ( // R18
        tx_load |=> s_r.tx_st == TX_SHIFT && !txd && s_r.tx_bits == 4'h0)
        else $error("buffered word not started");
    a_rx_two: assert property ( // R19
        s_r.rx_cnt == 2'h2 |-> !rx_word_ready ##0 !rx_push)
        else $error("receive buffer overfilled");

    c_stall: cover property (psel && penable && !pready);
    c_back_to_back: cover property (frame_end && tx_load);
    c_addr_hit: cover property (hit);
    c_rx_full: cover property (s_r.rx_cnt == 2'h2);
    c_irq: cover property (irq);
endmodule

//--- testbench/secs_peer.sv
`timescale 1ns/100ps
module secs_peer (
    input wire logic pclk,
    input wire logic txd,
    output logic [7:0] rx_word,
    output logic rx_word_valid,
    input wire logic rx_word_ready
);
    logic [7:0] got_q[$];
    int start_gap;
    time last_start;

    initial begin
        rx_word = 8'h00;
        rx_word_valid = 1'b0;
        start_gap = 0;
        last_start = 0;
    end

    // ----------------------------------------
    // frame receiver, sixteen cycles a bit
    // ----------------------------------------
    initial begin : rx_frames
        logic [7:0] b;
        forever begin
            @(negedge txd);
            start_gap = int'(($time - last_start) / 20);
            last_start = $time;
            repeat (8) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (16) @(posedge pclk);
                b[i] = txd;
            end
            repeat (16) @(posedge pclk);
            if (txd === 1'b1) begin
                got_q.push_back(b);
            end
        end
    end

    // word offered until the buffer takes it
    task automatic push(input logic [7:0] w);
        int n;
        n = 0;
        @(posedge pclk);
        rx_word <= w;
        rx_word_valid <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rx_word_ready !== 1'b1 && n < 500);
        rx_word <= ~w;
        rx_word_valid <= 1'b0;
    endtask
endmodule

//--- testbench/tb_serial_engine_common_services.sv
`timescale 1ns/100ps
module tb_serial_engine_common_services
    import secs_pkg::*;
    ;
    logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, rx_word, addr_in;
    logic [31:0] pwdata, prdata, q;
    logic txd, rx_word_valid, rx_word_ready, addr_valid, irq, err;
    int bad_count, checks;
    localparam logic [35:0] AM_CASES [0:13] = '{
        36'h05_00_5a_5a_1, 36'h05_00_5a_5b_0, 36'h05_ff_5a_13_1,
        36'h05_0f_50_5c_1, 36'h05_0f_50_6c_0, 36'h15_20_10_20_1,
        36'h15_20_10_10_1, 36'h15_20_10_30_0, 36'h25_20_40_20_1,
        36'h25_20_40_40_1, 36'h25_20_40_41_0, 36'h25_20_40_1f_0,
        36'h09_00_15_95_1, 36'h03_00_5a_5a_0};

    secs_core secs_core_i (.pclk(pclk), .presetn(presetn), .pce(pce),
        .psel(psel), .penable(penable), .paddr(paddr), .pwrite(pwrite),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .txd(txd), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready),
        .addr_in(addr_in), .addr_valid(addr_valid), .irq(irq));
    secs_peer secs_peer_i (.pclk(pclk), .txd(txd), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready));

    always #10 pclk = ~pclk;

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 100) begin
            bad_count++;
            stop_test();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic sync_wait();
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 20);
        chk(q, 32'h0);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_BAUD, 32'h0);
        rd_chk(OFS_IRQ_FLAG, 32'h0);
        rd_chk(OFS_IRQ_EN_SET, 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, txd}, 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    task automatic t_sync_cpf();
        apb(1'b1, OFS_CTRL, 32'h3);
        rd_chk(OFS_STATUS, 32'h1);
        sync_wait();
        rd_chk(OFS_IRQ_FLAG, 32'h8);
        apb(1'b1, OFS_CTRL, 32'h3);
        apb(1'b1, OFS_BAUD, 32'h0001_0196);
        rd_chk(OFS_BAUD, 32'h196);
        rd_chk(OFS_CTRL, 32'h3);
        repeat (400) @(posedge pclk);
        rd_chk(OFS_CPF, 32'ha0);
        apb(1'b1, OFS_BAUD, 32'h197);
        sync_wait();
        repeat (400) @(posedge pclk);
        rd_chk(OFS_CPF, 32'ha1);
    endtask

    task automatic t_irq();
        apb(1'b1, OFS_IRQ_FLAG, 32'hf);
        apb(1'b1, OFS_CTRL, 32'h3);
        sync_wait();
        apb(1'b1, OFS_IRQ_EN_SET, 32'h8);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(OFS_IRQ_FLAG, 32'h8);
        apb(1'b1, OFS_IRQ_FLAG, 32'h0);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFS_IRQ_EN_CLR, 32'h8);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_IRQ_EN_SET, 32'h0);
        rd_chk(OFS_IRQ_EN_SET, 32'h0);
        apb(1'b1, OFS_IRQ_EN_SET, 32'h8);
        apb(1'b1, OFS_IRQ_FLAG, 32'h8);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(OFS_IRQ_FLAG, 32'h0);
        apb(1'b1, OFS_IRQ_EN_CLR, 32'hf);
    endtask

    task automatic t_tx();
        int n;
        n = 0;
        apb(1'b1, OFS_BAUD, 32'h0);
        sync_wait();
        apb(1'b1, OFS_DATA, 32'ha5);
        apb(1'b1, OFS_DATA, 32'h3c);
        apb(1'b1, OFS_DATA, 32'hff);
        while (secs_peer_i.got_q.size() < 2 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        repeat (400) @(posedge pclk);
        chk(secs_peer_i.got_q.size(), 32'h2);
        chk(secs_peer_i.got_q[0], 32'ha5);
        chk(secs_peer_i.got_q[1], 32'h3c);
        chk(secs_peer_i.start_gap, 32'd160);
        apb(1'b0, OFS_IRQ_FLAG, 32'h0);
        chk(q & 32'h1, 32'h1);
        chk({31'h0, txd}, 32'h1);
    endtask

    task automatic t_rx();
        secs_peer_i.push(8'h11);
        secs_peer_i.push(8'h22);
        @(negedge pclk);
        chk({31'h0, rx_word_ready}, 32'h0);
        apb(1'b0, OFS_IRQ_FLAG, 32'h0);
        chk(q & 32'h2, 32'h2);
        rd_chk(OFS_DATA, 32'h11);
        @(negedge pclk);
        chk({31'h0, rx_word_ready}, 32'h1);
        rd_chk(OFS_DATA, 32'h22);
        // empty buffer: no pop, read pointer has wrapped to slot zero
        rd_chk(OFS_DATA, 32'h11);
    endtask

    task automatic t_addr();
        logic [35:0] c;
        foreach (AM_CASES[i]) begin
            c = AM_CASES[i];
            apb(1'b1, OFS_CTRL, {24'h0, c[35:28]});
            sync_wait();
            apb(1'b1, OFS_ADDR, {8'h0, c[27:20], 8'h0, c[19:12]});
            apb(1'b1, OFS_IRQ_FLAG, 32'h4);
            @(posedge pclk);
            addr_in <= c[11:4];
            addr_valid <= 1'b1;
            @(posedge pclk);
            addr_valid <= 1'b0;
            apb(1'b0, OFS_IRQ_FLAG, 32'h0);
            chk({31'h0, q[2]}, {31'h0, c[0]});
        end
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        pce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        addr_in = 8'h00;
        addr_valid = 1'b0;
        bad_count = 0;
        checks = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sync_cpf();
        t_irq();
        t_tx();
        t_rx();
        t_addr();
        stop_test();
    end

    initial begin
        #1_000_000;
        bad_count++;
        stop_test();
    end
endmodule
